// File: src/uart_aux_pkg.sv
// Package: register map, field positions and constants of the aux control
package uart_aux_pkg;
  // Register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_LEVELS_A = 8'h08;
  localparam logic [7:0] ADDR_LEVELS_B = 8'h0c;
  localparam logic [7:0] ADDR_DIVISOR_A = 8'h10;
  localparam logic [7:0] ADDR_DIVISOR_B = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_GLOBAL = 8'h1c;

  // Control register fields (per channel)
  localparam int FCR_LSB = 0;
  localparam int MCR_LSB = 8;
  localparam int IER_LSB = 16;
  localparam int ALT_FUNCTION_CTRL_ONE_LSB = 24;
  localparam int DMA_BIT = 3;
  localparam int LOOP_BIT = 4;
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_OUT1_BIT = 2;
  localparam int MCR_OUT2_BIT = 3;
  localparam int MCR_PRESC_BIT = 7;
  localparam int IER_SLEEP_BIT = 4;
  localparam int ALT_FUNCTION_CTRL_ONE_SLEEP_OVR_BIT = 4;
  localparam int EFR_ENH_BIT = 4;

  // Divisor register: low byte, high byte, fraction
  localparam int DIV_LOW_LSB = 0;
  localparam int DIV_HIGH_LSB = 8;
  localparam int DIV_FRAC_LSB = 16;

  // FIFO depths and full points
  localparam logic [7:0] FULL_NORMAL = 8'h20;
  localparam logic [7:0] FULL_EXTENDED = 8'h80;
  localparam logic [7:0] LEVEL_ZERO = 8'h00;

  // Idle window in character times, bits per character
  localparam logic [3:0] IDLE_CHARS = 4'h4;
  localparam logic [3:0] BITS_PER_CHAR = 4'ha;
  localparam logic [3:0] OVERSAMPLE = 4'hf;
  localparam logic [1:0] PRESC_QUARTER = 2'h3;

  localparam logic [31:0] RESET_CTRL = 32'h0000_0000;
  localparam logic [31:0] RESET_DIV = 32'h0000_0001;

  // Per-channel status from the UART core
  typedef struct packed {
    logic [7:0] rx_count;
    logic [7:0] tx_count;
    logic rx_trigger_hit;
    logic rx_timeout;
    logic tx_shift_empty;
    logic irq_pending;
  } chan_status_s;

  // Per-channel modem inputs
  typedef struct packed {
    logic cts;
    logic dsr;
    logic cd;
    logic ri;
  } modem_s;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SLEEP,
    PWR_LOW
  } pwr_state_e;
endpackage : uart_aux_pkg

// File: src/uart_dma_loopback_sleep_ctrl.sv
// Aux control of a two channel UART: DMA ready, loopback, sleep, baud
`timescale 1ns/100ps
module uart_dma_loopback_sleep_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // UART core status per channel
  input wire uart_aux_pkg::chan_status_s status_a_i,
  input wire uart_aux_pkg::chan_status_s status_b_i,
  input wire logic tx_load_a_i,
  input wire logic tx_load_b_i,
  input wire logic tx_serial_a_i,
  input wire logic tx_serial_b_i,
  input wire logic irq_a_i,
  input wire logic irq_b_i,
  // Pins
  input wire logic serial_in_pin_a_i,
  input wire logic serial_in_pin_b_i,
  input wire uart_aux_pkg::modem_s modem_pin_a_i,
  input wire uart_aux_pkg::modem_s modem_pin_b_i,
  input wire logic low_power_in_i,
  output logic serial_out_pin_a_o,
  output logic serial_out_pin_b_o,
  output logic rts_n_a_o,
  output logic rts_n_b_o,
  output logic dtr_n_a_o,
  output logic dtr_n_b_o,
  output logic irq_a_o,
  output logic irq_b_o,
  output logic irq_a_oe_n_o,
  output logic irq_b_oe_n_o,
  // Internal side toward the UART core
  output logic rx_serial_a_o,
  output logic rx_serial_b_o,
  output uart_aux_pkg::modem_s modem_a_o,
  output uart_aux_pkg::modem_s modem_b_o,
  output logic rx_ready_out_a_o,
  output logic rx_ready_out_b_o,
  output logic tx_ready_out_a_o,
  output logic tx_ready_out_b_o,
  output logic [7:0] full_level_o,
  output logic uart_clk_en_o,
  output logic baud_tick_a_o,
  output logic baud_tick_b_o,
  output logic asleep_o,
  output logic host_isolate_o
);

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  logic [31:0] ctrl_q [2];
  logic [31:0] levels_q [2];
  logic [31:0] div_q [2];
  logic [31:0] global_q;
  logic hit;
  uart_aux_pkg::pwr_state_e pwr_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Single cycle answer; host isolated in low-power mode
  wire req = cyc_i && stb_i && !ack_o && !host_isolate_o;
  wire wr = req && we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q[0] <= uart_aux_pkg::RESET_CTRL;
      ctrl_q[1] <= uart_aux_pkg::RESET_CTRL;
      levels_q[0] <= uart_aux_pkg::RESET_CTRL;
      levels_q[1] <= uart_aux_pkg::RESET_CTRL;
      div_q[0] <= uart_aux_pkg::RESET_DIV;
      div_q[1] <= uart_aux_pkg::RESET_DIV;
      global_q <= uart_aux_pkg::RESET_CTRL;
    end else if (wr) begin
      case (adr_i)
        uart_aux_pkg::ADDR_CTRL_A: ctrl_q[0] <= merge(ctrl_q[0], dat_i, sel_i);
        uart_aux_pkg::ADDR_CTRL_B: ctrl_q[1] <= merge(ctrl_q[1], dat_i, sel_i);
        uart_aux_pkg::ADDR_LEVELS_A: begin
          levels_q[0] <= merge(levels_q[0], dat_i, sel_i);
        end
        uart_aux_pkg::ADDR_LEVELS_B: begin
          levels_q[1] <= merge(levels_q[1], dat_i, sel_i);
        end
        // Written while asleep is unsafe; host keeps off
        uart_aux_pkg::ADDR_DIVISOR_A: div_q[0] <= merge(div_q[0], dat_i, sel_i);
        uart_aux_pkg::ADDR_DIVISOR_B: div_q[1] <= merge(div_q[1], dat_i, sel_i);
        uart_aux_pkg::ADDR_GLOBAL: global_q <= merge(global_q, dat_i, sel_i);
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Per-channel views
  // ------------------------------------------------------------------
  uart_aux_pkg::chan_status_s st [2];
  uart_aux_pkg::modem_s mpin [2];
  uart_aux_pkg::modem_s modem_int [2];
  logic [1:0] dma, loop, sleep_en, sleep_ovr, sin_pin, sin_int, tx_in;
  logic [1:0] rdy_rx_q, rdy_tx_q, tx_load;
  logic extended;
  logic [7:0] full_lvl;

  assign st[0] = status_a_i;
  assign st[1] = status_b_i;
  assign mpin[0] = modem_pin_a_i;
  assign mpin[1] = modem_pin_b_i;
  assign sin_pin = {serial_in_pin_b_i, serial_in_pin_a_i};
  assign tx_in = {tx_serial_b_i, tx_serial_a_i};
  assign tx_load = {tx_load_b_i, tx_load_a_i};

  // Any nonzero level byte switches both channels to deep FIFOs
  assign extended = (levels_q[0] != {4{uart_aux_pkg::LEVEL_ZERO}}) ||
                    (levels_q[1] != {4{uart_aux_pkg::LEVEL_ZERO}});
  assign full_lvl = extended ? uart_aux_pkg::FULL_EXTENDED
                             : uart_aux_pkg::FULL_NORMAL;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire [7:0] fifo_control_reg = ctrl_q[c][uart_aux_pkg::FCR_LSB +: 8];
    wire [7:0] modem_control_reg = ctrl_q[c][uart_aux_pkg::MCR_LSB +: 8];
    wire [7:0] interrupt_enable_reg = ctrl_q[c][uart_aux_pkg::IER_LSB +: 8];
    wire [7:0] afc = ctrl_q[c][uart_aux_pkg::ALT_FUNCTION_CTRL_ONE_LSB +: 8];
    assign dma[c] = fifo_control_reg[uart_aux_pkg::DMA_BIT];
    assign loop[c] = modem_control_reg[uart_aux_pkg::LOOP_BIT];
    assign sleep_en[c] = interrupt_enable_reg[uart_aux_pkg::IER_SLEEP_BIT];
    assign sleep_ovr[c] = afc[uart_aux_pkg::ALT_FUNCTION_CTRL_ONE_SLEEP_OVR_BIT];
    assign sin_int[c] = loop[c] ? tx_in[c] : sin_pin[c];
    always_comb begin
      if (loop[c]) begin
        modem_int[c].cts = modem_control_reg[uart_aux_pkg::MCR_RTS_BIT];
        modem_int[c].dsr = modem_control_reg[uart_aux_pkg::MCR_DTR_BIT];
        modem_int[c].cd = modem_control_reg[uart_aux_pkg::MCR_OUT2_BIT];
        modem_int[c].ri = modem_control_reg[uart_aux_pkg::MCR_OUT1_BIT];
      end else begin
        modem_int[c] = mpin[c];
      end
    end

    // Ready pins, one pair per channel; only the tx pin in DMA mode uses the shared full level
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rdy_rx_q[c] <= 1'b1;
        rdy_tx_q[c] <= 1'b0;
      end else if (!dma[c]) begin
        rdy_rx_q[c] <= (st[c].rx_count == 8'h00);
        rdy_tx_q[c] <= (st[c].tx_count != 8'h00);
      end else begin
        if (st[c].rx_count == 8'h00) begin
          rdy_rx_q[c] <= 1'b1;
        end else if (st[c].rx_trigger_hit || st[c].rx_timeout) begin
          rdy_rx_q[c] <= 1'b0;
        end
        if (st[c].tx_count >= full_lvl) begin
          rdy_tx_q[c] <= 1'b1;
        end else begin
          rdy_tx_q[c] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Baud generator
  // ------------------------------------------------------------------
  logic [1:0] presc_q [2];
  logic [15:0] base_q [2];
  logic [3:0] frac_q [2];
  logic [3:0] os_q [2];
  logic [1:0] bit_tick;
  wire run_en = (pwr_q == uart_aux_pkg::PWR_RUN);

  function automatic logic [15:0] divisor(input logic [31:0] d);
    logic [15:0] n;
    n = {d[uart_aux_pkg::DIV_HIGH_LSB +: 8], d[uart_aux_pkg::DIV_LOW_LSB +: 8]};
    return (n == 16'h0000) ? 16'h0001 : n;
  endfunction : divisor

  for (genvar c = 0; c < 2; c++) begin : g_baud
    wire quarter = ctrl_q[c][uart_aux_pkg::MCR_LSB + uart_aux_pkg::MCR_PRESC_BIT];
    wire [3:0] frac = div_q[c][uart_aux_pkg::DIV_FRAC_LSB +: 4];
    wire presc_tick = !quarter || (presc_q[c] == uart_aux_pkg::PRESC_QUARTER);
    // Fraction spreads M extra input cycles over 16 ticks
    wire [4:0] frac_sum = {1'b0, frac_q[c]} + {1'b0, frac};
    wire [15:0] reload = divisor(div_q[c]) - 16'h0001 +
                         {15'h0000, frac_sum[4]};
    wire tick16 = run_en && presc_tick && (base_q[c] == 16'h0000);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        presc_q[c] <= 2'h0;
        base_q[c] <= 16'h0000;
        frac_q[c] <= 4'h0;
        os_q[c] <= 4'h0;
      end else if (run_en) begin
        presc_q[c] <= presc_tick ? 2'h0 : presc_q[c] + 2'h1;
        if (presc_tick) begin
          if (base_q[c] == 16'h0000) begin
            base_q[c] <= reload;
            frac_q[c] <= frac_sum[3:0];
          end else begin
            base_q[c] <= base_q[c] - 16'h0001;
          end
        end
        if (tick16) begin
          os_q[c] <= os_q[c] + 4'h1;
        end
      end
    end
    assign bit_tick[c] = tick16 && (os_q[c] == uart_aux_pkg::OVERSAMPLE);
  end

  // ------------------------------------------------------------------
  // Sleep control
  // ------------------------------------------------------------------
  logic [1:0] sin_d_q, modem_chg;
  logic [3:0] bit_cnt_q [2];
  logic [3:0] chr_cnt_q [2];
  logic [1:0] idle_ok;
  uart_aux_pkg::modem_s modem_d_q [2];
  wire enh = global_q[uart_aux_pkg::EFR_ENH_BIT];
  wire allowed = enh && (&sleep_en);

  for (genvar c = 0; c < 2; c++) begin : g_idle
    // Bit ticks stop in sleep and low power; the idle count holds until run unless a low serial input clears it
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sin_d_q[c] <= 1'b1;
        modem_d_q[c] <= '0;
        bit_cnt_q[c] <= 4'h0;
        chr_cnt_q[c] <= 4'h0;
      end else begin
        sin_d_q[c] <= sin_int[c];
        modem_d_q[c] <= modem_int[c];
        if (!sin_int[c]) begin
          bit_cnt_q[c] <= 4'h0;
          chr_cnt_q[c] <= 4'h0;
        end else if (bit_tick[c] && chr_cnt_q[c] != uart_aux_pkg::IDLE_CHARS) begin
          if (bit_cnt_q[c] == uart_aux_pkg::BITS_PER_CHAR - 4'h1) begin
            bit_cnt_q[c] <= 4'h0;
            chr_cnt_q[c] <= chr_cnt_q[c] + 4'h1;
          end else begin
            bit_cnt_q[c] <= bit_cnt_q[c] + 4'h1;
          end
        end
      end
    end
    assign modem_chg[c] = (modem_d_q[c] != modem_int[c]);
    assign idle_ok[c] = sleep_ovr[c] ||
                        (chr_cnt_q[c] == uart_aux_pkg::IDLE_CHARS);
  end

  wire quiet = !(|modem_chg) && (&idle_ok) &&
               (st[0].tx_count == 8'h00) && (st[1].tx_count == 8'h00) &&
               st[0].tx_shift_empty && st[1].tx_shift_empty &&
               !st[0].irq_pending && !st[1].irq_pending &&
               (st[0].rx_count == 8'h00) && (st[1].rx_count == 8'h00);
  wire start_bit = (sin_d_q[0] && !sin_int[0]) || (sin_d_q[1] && !sin_int[1]);
  wire wake = start_bit || (|tx_load) || (|modem_chg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q <= uart_aux_pkg::PWR_RUN;
    end else begin
      case (pwr_q)
        uart_aux_pkg::PWR_RUN: begin
          if (low_power_in_i) begin
            pwr_q <= uart_aux_pkg::PWR_LOW;
          end else if (allowed && quiet) begin
            pwr_q <= uart_aux_pkg::PWR_SLEEP;
          end
        end
        uart_aux_pkg::PWR_SLEEP: begin
          if (low_power_in_i) begin
            pwr_q <= uart_aux_pkg::PWR_LOW;
          end else if (wake || !allowed) begin
            pwr_q <= uart_aux_pkg::PWR_RUN;
          end
        end
        uart_aux_pkg::PWR_LOW: begin
          if (!low_power_in_i) begin
            pwr_q <= uart_aux_pkg::PWR_RUN;
          end
        end
        default: pwr_q <= uart_aux_pkg::PWR_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_comb begin
    dat_o = 32'h0000_0000;
    if (ack_o && !we_i) begin
      case (adr_i)
        uart_aux_pkg::ADDR_CTRL_A: dat_o = ctrl_q[0];
        uart_aux_pkg::ADDR_CTRL_B: dat_o = ctrl_q[1];
        uart_aux_pkg::ADDR_LEVELS_A: dat_o = levels_q[0];
        uart_aux_pkg::ADDR_LEVELS_B: dat_o = levels_q[1];
        uart_aux_pkg::ADDR_DIVISOR_A: dat_o = div_q[0];
        uart_aux_pkg::ADDR_DIVISOR_B: dat_o = div_q[1];
        uart_aux_pkg::ADDR_GLOBAL: dat_o = global_q;
        uart_aux_pkg::ADDR_STATUS: begin
          dat_o = {16'h0000, full_lvl, 2'b00, pwr_q, rdy_tx_q, rdy_rx_q};
        end
        default: dat_o = 32'h0000_0000;
      endcase
    end
  end

  // Loopback keeps serial out idle and floats the interrupt
  assign serial_out_pin_a_o = loop[0] ? 1'b1 : tx_serial_a_i;
  assign serial_out_pin_b_o = loop[1] ? 1'b1 : tx_serial_b_i;
  assign rts_n_a_o = loop[0] | ~ctrl_q[0][uart_aux_pkg::MCR_LSB + uart_aux_pkg::MCR_RTS_BIT];
  assign rts_n_b_o = loop[1] | ~ctrl_q[1][uart_aux_pkg::MCR_LSB + uart_aux_pkg::MCR_RTS_BIT];
  assign dtr_n_a_o = loop[0] | ~ctrl_q[0][uart_aux_pkg::MCR_LSB + uart_aux_pkg::MCR_DTR_BIT];
  assign dtr_n_b_o = loop[1] | ~ctrl_q[1][uart_aux_pkg::MCR_LSB + uart_aux_pkg::MCR_DTR_BIT];
  assign irq_a_o = irq_a_i;
  assign irq_b_o = irq_b_i;
  assign irq_a_oe_n_o = loop[0];
  assign irq_b_oe_n_o = loop[1];
  assign rx_serial_a_o = sin_int[0];
  assign rx_serial_b_o = sin_int[1];
  assign modem_a_o = modem_int[0];
  assign modem_b_o = modem_int[1];
  assign rx_ready_out_a_o = rdy_rx_q[0];
  assign rx_ready_out_b_o = rdy_rx_q[1];
  assign tx_ready_out_a_o = rdy_tx_q[0];
  assign tx_ready_out_b_o = rdy_tx_q[1];
  assign full_level_o = full_lvl;
  assign uart_clk_en_o = run_en;
  assign baud_tick_a_o = g_baud[0].tick16;
  assign baud_tick_b_o = g_baud[1].tick16;
  assign asleep_o = (pwr_q == uart_aux_pkg::PWR_SLEEP);
  assign host_isolate_o = (pwr_q == uart_aux_pkg::PWR_LOW);

endmodule : uart_dma_loopback_sleep_ctrl

// File: bench/uart_core_model.sv
// Behavioural UART core model: FIFO counts and status toward the block
`timescale 1ns/100ps
module uart_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] op_i,
  input wire logic irq_i,
  input wire logic [7:0] trig_i,
  output uart_aux_pkg::chan_status_s status_o,
  output logic tx_load_o
);
  // ----------------------------------------------------------------
  // FIFO fill, op_i: rx push, rx pop, tx push, tx pop, timeout
  // ----------------------------------------------------------------
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_q <= 8'h00;
      tx_q <= 8'h00;
    end else begin
      rx_q <= rx_q + 8'(op_i[0]) - 8'(op_i[1]);
      tx_q <= tx_q + 8'(op_i[2]) - 8'(op_i[3]);
    end
  end
  assign tx_load_o = op_i[2];
  // Timeout only while bytes wait, as a real receiver does
  assign status_o = '{rx_q, tx_q, trig_i != 8'h00 && rx_q >= trig_i,
    op_i[4] && rx_q != 8'h00, tx_q == 8'h00, irq_i};
endmodule : uart_core_model

// File: bench/uart_aux_asserts.sv
// Concurrent checks on the aux control ports
`timescale 1ns/100ps
module uart_aux_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire uart_aux_pkg::chan_status_s status_a_i,
  input wire logic tx_load_a_i,
  input wire logic tx_serial_a_i,
  input wire logic serial_in_pin_a_i,
  input wire logic low_power_in_i,
  input wire logic irq_a_oe_n_o,
  input wire logic rx_serial_a_o,
  input wire logic rx_ready_out_a_o,
  input wire logic tx_ready_out_a_o,
  input wire logic [7:0] full_level_o,
  input wire logic uart_clk_en_o,
  input wire logic baud_tick_a_o,
  input wire logic asleep_o,
  input wire logic host_isolate_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence take_s;
    cyc_i && stb_i && !ack_o && !host_isolate_o;
  endsequence
  sequence ack_s;
    ack_o ##1 !ack_o;
  endsequence
  sequence lp_s;
    low_power_in_i [*2];
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_ack_once: assert property (take_s |=> ack_s)
    else $error("ack not a single cycle after request");
  chk_rx_empty: assert property (
    status_a_i.rx_count == 8'h00 |=> rx_ready_out_a_o)
    else $error("rx ready low with empty fifo");
  chk_rx_trig: assert property (
    status_a_i.rx_count != 8'h00 && (status_a_i.rx_trigger_hit ||
    status_a_i.rx_timeout) |=> !rx_ready_out_a_o)
    else $error("rx ready high at trigger");
  chk_tx_full: assert property (
    status_a_i.tx_count >= full_level_o && status_a_i.tx_count != 8'h00
    |=> tx_ready_out_a_o)
    else $error("tx ready low at full");
  chk_tx_empty: assert property (
    status_a_i.tx_count == 8'h00 |=> !tx_ready_out_a_o)
    else $error("tx ready high with empty fifo");
  chk_full_lvl: assert property (
    full_level_o == 8'h20 || full_level_o == 8'h80)
    else $error("full level neither 32 nor 128");
  chk_loop_rx: assert property (
    irq_a_oe_n_o |-> rx_serial_a_o == tx_serial_a_i)
    else $error("loopback rx not fed by transmitter");
  chk_sleep_clk: assert property (
    asleep_o |-> !uart_clk_en_o && !baud_tick_a_o)
    else $error("clocks run while asleep");
  chk_wake_evt: assert property (
    asleep_o && (tx_load_a_i || (!irq_a_oe_n_o &&
    $fell(serial_in_pin_a_i))) |-> ##[1:2] !asleep_o)
    else $error("no wake on event");
  chk_lp_hold: assert property (
    lp_s |-> host_isolate_o && !uart_clk_en_o)
    else $error("low power not entered");
  chk_lp_exit: assert property (
    !low_power_in_i [*3] |-> !host_isolate_o)
    else $error("host still isolated");
endmodule : uart_aux_asserts

bind uart_dma_loopback_sleep_ctrl uart_aux_asserts u_chk (.clk_i, .rst_i,
  .cyc_i, .stb_i, .ack_o, .status_a_i, .tx_load_a_i, .tx_serial_a_i,
  .serial_in_pin_a_i, .low_power_in_i, .irq_a_oe_n_o, .rx_serial_a_o,
  .rx_ready_out_a_o, .tx_ready_out_a_o, .full_level_o, .uart_clk_en_o,
  .baud_tick_a_o, .asleep_o, .host_isolate_o);

// File: bench/uart_dma_loopback_sleep_ctrl_tb_top.sv
// Self-checking bench of the aux control block
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uart_dma_loopback_sleep_ctrl_tb_top;
  logic clk_i, rst_i, cyc, we, ack, txs_a, sin_a, irq_a, lp;
  logic sout_a, oen_a, rxs_a, rr_a, rr_b, tr_a, tr_b, clken, bt_a, slp, iso;
  logic ld_a, ld_b, rts_na, dtr_na, irqo_a;
  logic [3:0] sel;
  logic [7:0] adr, trig, full;
  logic [31:0] dw, dr, rdv;
  logic [1:0][4:0] ctl;
  uart_aux_pkg::modem_s mod_a, mo_a;
  uart_aux_pkg::chan_status_s st_a, st_b;
  int errors, checks_done, m;

  uart_core_model core_a (.clk_i, .rst_i, .op_i(ctl[0]), .irq_i(irq_a),
    .trig_i(trig), .status_o(st_a), .tx_load_o(ld_a));
  uart_core_model core_b (.clk_i, .rst_i, .op_i(ctl[1]), .irq_i(1'b0),
    .trig_i(trig), .status_o(st_b), .tx_load_o(ld_b));
  uart_dma_loopback_sleep_ctrl uut (.clk_i, .rst_i, .cyc_i(cyc),
    .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dw),
    .dat_o(dr), .ack_o(ack), .status_a_i(st_a), .status_b_i(st_b),
    .tx_load_a_i(ld_a), .tx_load_b_i(ld_b), .tx_serial_a_i(txs_a),
    .tx_serial_b_i(1'b1), .irq_a_i(irq_a), .irq_b_i(1'b0),
    .serial_in_pin_a_i(sin_a), .serial_in_pin_b_i(1'b1),
    .modem_pin_a_i(mod_a), .modem_pin_b_i(4'h0), .low_power_in_i(lp),
    .serial_out_pin_a_o(sout_a), .serial_out_pin_b_o(), .rts_n_a_o(rts_na),
    .rts_n_b_o(), .dtr_n_a_o(dtr_na), .dtr_n_b_o(), .irq_a_o(irqo_a),
    .irq_b_o(),
    .irq_a_oe_n_o(oen_a), .irq_b_oe_n_o(), .rx_serial_a_o(rxs_a),
    .rx_serial_b_o(), .modem_a_o(mo_a), .modem_b_o(),
    .rx_ready_out_a_o(rr_a), .rx_ready_out_b_o(rr_b),
    .tx_ready_out_a_o(tr_a), .tx_ready_out_b_o(tr_b), .full_level_o(full),
    .uart_clk_en_o(clken), .baud_tick_a_o(bt_a), .baud_tick_b_o(),
    .asleep_o(slp), .host_isolate_o(iso));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // Wishbone classic cycle; no fixed latency is assumed
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdv = dr;
    if (n >= 50) errors++;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(rdv, e)
  endtask : rd

  // Hold one core operation for n cycles, then let ready pins settle
  task automatic op(input int ch, input int k, input int n);
    ctl[ch][k] <= 1'b1;
    repeat (n) @(posedge clk_i);
    ctl[ch][k] <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : op

  task automatic wsl(input logic e);
    int n;
    n = 0;
    while (slp !== e && n < 1500) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(slp, e)
  endtask : wsl

  // Cycles spanned by sixteen baud tick intervals
  task automatic meas(input int e);
    int n, t;
    n = 0;
    t = 0;
    while (bt_a !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (t < 16 && n < 9000) begin
      @(posedge clk_i);
      n++;
      if (bt_a === 1'b1) t++;
    end
    `CHK(n, e)
  endtask : meas

  // ----------------------------------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    conclude();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    rst_i = 1'b1;
    {cyc, we, irq_a, lp} = 4'h0;
    {txs_a, sin_a} = 2'h3;
    {adr, trig, dw, ctl} = '0;
    sel = 4'hf;
    mod_a = 4'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(uart_aux_pkg::ADDR_CTRL_A, 32'h0000_0000);
    rd(uart_aux_pkg::ADDR_DIVISOR_A, 32'h0000_0001);
    rd(uart_aux_pkg::ADDR_STATUS, 32'h0000_2003);
    rd(8'h40, 32'h0000_0000);
    // Single byte lane reaches only the fraction byte
    sel <= 4'h4;
    wr(uart_aux_pkg::ADDR_DIVISOR_A, 32'hffff_ffff);
    sel <= 4'hf;
    rd(uart_aux_pkg::ADDR_DIVISOR_A, 32'h00ff_0001);
    op(0, 0, 1);
    `CHK({rr_a, rr_b}, 2'b01)
    op(0, 2, 1);
    `CHK({tr_a, tr_b}, 2'b10)
    op(0, 1, 1);
    op(0, 3, 1);
    `CHK({rr_a, tr_a}, 2'b10)
    wr(uart_aux_pkg::ADDR_CTRL_A, 32'h0000_0008);
    trig <= 8'h04;
    op(0, 0, 3);
    `CHK(rr_a, 1'b1)
    op(0, 0, 1);
    `CHK(rr_a, 1'b0)
    op(0, 1, 4);
    `CHK(rr_a, 1'b1)
    op(0, 0, 1);
    op(0, 4, 1);
    `CHK(rr_a, 1'b0)
    op(0, 1, 1);
    op(0, 2, 31);
    `CHK(tr_a, 1'b0)
    op(0, 2, 1);
    `CHK(tr_a, 1'b1)
    op(0, 3, 1);
    `CHK(tr_a, 1'b0)
    wr(uart_aux_pkg::ADDR_LEVELS_B, 32'h0100_0000);
    `CHK(full, 8'h80)
    op(0, 2, 1);
    `CHK(tr_a, 1'b0)
    wr(uart_aux_pkg::ADDR_LEVELS_B, 32'h0000_0000);
    op(0, 3, 32);
    `CHK(full, 8'h20)
    for (m = 0; m < 16; m++) begin
      txs_a <= ~m[0];
      mod_a <= 4'(~m);
      wr(uart_aux_pkg::ADDR_CTRL_A, {16'h0000, 4'h1, 4'(m), 8'h00});
      `CHK(mo_a, 4'({m[1], m[0], m[3], m[2]}))
      `CHK({rxs_a, sout_a, oen_a}, {~m[0], 2'b11})
    end
    irq_a <= 1'b1;
    wr(uart_aux_pkg::ADDR_CTRL_A, 32'h0000_0300);
    txs_a <= 1'b1;
    `CHK({rxs_a, oen_a, rts_na, dtr_na, irqo_a}, 5'b10001)
    irq_a <= 1'b0;
    wr(uart_aux_pkg::ADDR_DIVISOR_A, 32'h0000_000c);
    meas(192);
    wr(uart_aux_pkg::ADDR_CTRL_A, 32'h0000_8000);
    meas(768);
    wr(uart_aux_pkg::ADDR_CTRL_A, 32'h0000_0000);
    wr(uart_aux_pkg::ADDR_DIVISOR_A, 32'h0008_0002);
    meas(40);
    wr(uart_aux_pkg::ADDR_DIVISOR_A, 32'h0000_0100);
    meas(4096);
    // Divisor settled before sleep may start
    wr(uart_aux_pkg::ADDR_DIVISOR_A, 32'h0000_0001);
    wr(uart_aux_pkg::ADDR_GLOBAL, 32'h0000_0010);
    wr(uart_aux_pkg::ADDR_CTRL_A, 32'h0010_0000);
    `CHK(slp, 1'b0)
    sin_a <= 1'b0;
    repeat (4) @(posedge clk_i);
    sin_a <= 1'b1;
    wr(uart_aux_pkg::ADDR_CTRL_B, 32'h0010_0000);
    `CHK(slp, 1'b0)
    wsl(1'b1);
    `CHK({clken, bt_a}, 2'b00)
    op(0, 2, 1);
    `CHK(slp, 1'b0)
    op(0, 3, 1);
    wsl(1'b1);
    sin_a <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(slp, 1'b0)
    sin_a <= 1'b1;
    wsl(1'b1);
    mod_a <= 4'h5;
    wsl(1'b0);
    wsl(1'b1);
    wr(uart_aux_pkg::ADDR_CTRL_A, 32'h1010_0000);
    sin_a <= 1'b0;
    repeat (3) @(posedge clk_i);
    wsl(1'b1);
    sin_a <= 1'b1;
    wr(uart_aux_pkg::ADDR_CTRL_B, 32'h0000_0000);
    repeat (50) @(posedge clk_i);
    `CHK({slp, clken}, 2'b01)
    lp <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK({iso, clken}, 2'b10)
    lp <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(uart_aux_pkg::ADDR_STATUS, 32'h0000_2003);
    conclude();
  end
endmodule : uart_dma_loopback_sleep_ctrl_tb_top
